// *** design/interval_timer.sv ***
// millisecond interval timer with a one-cycle expiry pulse
`timescale 1ns/1ps
`include "switch_irq_defines.svh"

module interval_timer #(
	parameter int TICK_CYCLES = 20000
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    run_in,
	input  wire switch_irq_pkg::ms_count_t period_ms_in,
	output logic                         expire_out
);
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	logic [PRE_W-1:0]          pre_q;
	switch_irq_pkg::ms_count_t ms_q;
	logic                      ms_tick;
	logic                      active;

	// a zero period means the timer is switched off and never fires
	assign active  = run_in && (period_ms_in != '0);
	assign ms_tick = active && (pre_q == PRE_LAST);

	// =================================================================
	// prescaler down to one millisecond
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pre_q <= '0;
		end else if (!active || ms_tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// =================================================================
	// millisecond counter; >= guards a period shortened mid-count
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ms_q       <= '0;
			expire_out <= 1'b0;
		end else if (!active) begin
			ms_q       <= '0;
			expire_out <= 1'b0;
		end else if (ms_tick && (ms_q + 10'h001 >= period_ms_in)) begin
			ms_q       <= '0;
			expire_out <= 1'b1;
		end else begin
			ms_q       <= ms_tick ? ms_q + 10'h001 : ms_q;
			expire_out <= 1'b0;
		end
	end

endmodule

// *** design/switch_irq_defines.svh ***
// constants for the switch interrupt mask and sleep timer block
// Functional notes
// RULE1: an input whose enable bit is zero never raises the interrupt flag on change
// RULE2: an input whose enable bit is one raises the flag on change in normal mode
// RULE3: enable registers may be rewritten any time and take effect at once
// RULE4: after reset every implemented interrupt enable bit reads one
// RULE5: programmable input enables live at address 0x0d, bits 7..0, rest zero
// RULE6: ground switch enables live at address 0x0e, bits 13..0, rest zero
// RULE7: frame is address 31..25, read/write bit 24, data 23..0
// RULE8: return word carries fault in bit 23, interrupt flag in 22, data below
// RULE9: sleep config at 0x0f, wake select 7..4 reset 0, poll select 3..0 reset f
// RULE10: asleep with a wake time selected, wake and raise interrupt on expiry
// RULE11: wake select zero means the wake timer never wakes the device
// RULE12: poll select sets the time between polling events while asleep
// RULE13: each polling event opens separate ground and battery current windows
// RULE14: wake codes map to off, 6..394 ms and 4..512 ms
// RULE15: poll codes map to 3..128 ms and 32..64 ms, default 64 ms
// RULE16: unused bits ignore writes and read back zero
// RULE17: a read leaves the register unchanged, a write updates implemented bits only
`ifndef SWITCH_IRQ_DEFINES_SVH
`define SWITCH_IRQ_DEFINES_SVH

// =====================================================================
// frame layout
`define FRAME_BITS      32
`define FRAME_CNT_W     6
`define ADDR_MSB        31
`define ADDR_LSB        25
`define RW_BIT          24
`define DATA_MSB        23
`define RESP_FAULT_BIT  23
`define RESP_IRQ_BIT    22
`define RESP_DATA_MSB   21
`define RESP_DATA_W     22

// =====================================================================
// register map and fields
`define ADDR_PI_IRQ_EN  7'h0d
`define ADDR_GS_IRQ_EN  7'h0e
`define ADDR_SLEEP_CFG  7'h0f
`define PI_W            8
`define GS_W            14
`define CFG_W           8
`define PI_IRQ_EN_RST   8'hff
`define GS_IRQ_EN_RST   14'h3fff
`define SLEEP_CFG_RST   8'h0f
`define WAKE_MSB        7
`define WAKE_LSB        4
`define POLL_MSB        3
`define POLL_LSB        0
`define WAKE_OFF        4'h0

// =====================================================================
// timing
`define CLK_PERIOD_NS   50
`define NS_PER_MS       1000000
`define NS_PER_US       1000
`define MS_W            10
`define ON_CNT_W        16

// =====================================================================
// wake interval table in ms; code zero is the off setting
`define WAKE_MS_0       10'h000
`define WAKE_MS_1       10'h006
`define WAKE_MS_2       10'h00c
`define WAKE_MS_3       10'h018
`define WAKE_MS_4       10'h030
`define WAKE_MS_5       10'h060
`define WAKE_MS_6       10'h0c0
`define WAKE_MS_7       10'h18a
`define WAKE_MS_8       10'h004
`define WAKE_MS_9       10'h008
`define WAKE_MS_A       10'h010
`define WAKE_MS_B       10'h020
`define WAKE_MS_C       10'h040
`define WAKE_MS_D       10'h080
`define WAKE_MS_E       10'h100
`define WAKE_MS_F       10'h200

// =====================================================================
// poll interval table in ms
`define POLL_MS_0       10'h003
`define POLL_MS_1       10'h006
`define POLL_MS_2       10'h00c
`define POLL_MS_3       10'h018
`define POLL_MS_4       10'h030
`define POLL_MS_5       10'h044
`define POLL_MS_6       10'h04c
`define POLL_MS_7       10'h080
`define POLL_MS_8       10'h020
`define POLL_MS_9       10'h024
`define POLL_MS_A       10'h028
`define POLL_MS_B       10'h02c
`define POLL_MS_C       10'h034
`define POLL_MS_D       10'h038
`define POLL_MS_E       10'h03c
`define POLL_MS_F       10'h040

`endif

// *** design/switch_irq_mask.sv ***
// serial register slave with interrupt masking and sleep wake/poll timers
`timescale 1ns/1ps
`include "switch_irq_defines.svh"

module switch_irq_mask #(
	parameter int MS_TICK_CYCLES     = `NS_PER_MS / `CLK_PERIOD_NS,
	parameter int GROUND_POLL_ON_US  = 100,
	parameter int BATTERY_POLL_ON_US = 200
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             spi_sclk_in,
	input  wire logic             spi_cs_n_in,
	input  wire logic             spi_mosi_in,
	output logic                  spi_miso_out,
	output logic                  spi_miso_oe_n_out,
	input  wire logic [`PI_W-1:0] programmable_input_in,
	input  wire logic [`GS_W-1:0] ground_switch_input_in,
	input  wire logic             sleep_state_in,
	input  wire logic             fault_summary_in,
	output logic                  irq_flag_out,
	output logic                  wake_out,
	output logic                  ground_poll_on_out,
	output logic                  battery_poll_on_out
);
	// least on-times, rounded up to whole cycles
	localparam int GROUND_ON_CYCLES  = (GROUND_POLL_ON_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int BATTERY_ON_CYCLES = (BATTERY_POLL_ON_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	// =================================================================
	// decode helpers: period tables in ms, indexed by the select code
	localparam switch_irq_pkg::ms_count_t WAKE_TABLE [16] = '{`WAKE_MS_0, `WAKE_MS_1, `WAKE_MS_2, `WAKE_MS_3,
		`WAKE_MS_4, `WAKE_MS_5, `WAKE_MS_6, `WAKE_MS_7, `WAKE_MS_8, `WAKE_MS_9, `WAKE_MS_A, `WAKE_MS_B,
		`WAKE_MS_C, `WAKE_MS_D, `WAKE_MS_E, `WAKE_MS_F};
	localparam switch_irq_pkg::ms_count_t POLL_TABLE [16] = '{`POLL_MS_0, `POLL_MS_1, `POLL_MS_2, `POLL_MS_3,
		`POLL_MS_4, `POLL_MS_5, `POLL_MS_6, `POLL_MS_7, `POLL_MS_8, `POLL_MS_9, `POLL_MS_A, `POLL_MS_B,
		`POLL_MS_C, `POLL_MS_D, `POLL_MS_E, `POLL_MS_F};

	// the off code maps to a zero period, which the timer treats as switched off
	function automatic switch_irq_pkg::ms_count_t wake_ms(input switch_irq_pkg::sel_code_t code);
		wake_ms = WAKE_TABLE[code]; // RULE14 RULE11
	endfunction

	function automatic switch_irq_pkg::ms_count_t poll_ms(input switch_irq_pkg::sel_code_t code);
		poll_ms = POLL_TABLE[code]; // RULE15
	endfunction

	// =================================================================
	// link domain: frame shifter on the serial clock
	logic                     link_rst;
	logic [`FRAME_CNT_W-1:0]  bit_cnt_q;
	logic [`FRAME_BITS-2:0]   shift_q;
	switch_irq_pkg::frame_word_t frame_hold_q;
	logic                     req_tgl_q;
	switch_irq_pkg::frame_word_t resp_q;
	logic [4:0]               miso_idx;

	// chip select high holds the shifter idle, so a short frame is dropped
	assign link_rst = sys_rst_in | spi_cs_n_in;

	// count and shift mosi in, msb first; bits past 32 are ignored
	always_ff @(posedge spi_sclk_in or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_q <= '0;
			shift_q   <= '0;
		end else if (bit_cnt_q != `FRAME_CNT_W'(`FRAME_BITS)) begin
			bit_cnt_q <= bit_cnt_q + `FRAME_CNT_W'(1);
			shift_q   <= {shift_q[`FRAME_BITS-3:0], spi_mosi_in}; // RULE7
		end
	end

	// the last bit closes the frame: hold it and toggle the request
	always_ff @(posedge spi_sclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_hold_q <= '0;
			req_tgl_q    <= 1'b0;
		end else if (!spi_cs_n_in && bit_cnt_q == `FRAME_CNT_W'(`FRAME_BITS - 1)) begin
			frame_hold_q <= {shift_q, spi_mosi_in}; // RULE7
			req_tgl_q    <= ~req_tgl_q;
		end
	end

	// resp_q is only rewritten between frames, so it is stable while shifted
	assign miso_idx          = ~bit_cnt_q[4:0];
	assign spi_miso_out      = spi_cs_n_in ? 1'b0 : resp_q[miso_idx];
	assign spi_miso_oe_n_out = spi_cs_n_in;

	chk_frame_count: assert property (@(posedge spi_sclk_in) disable iff (link_rst) // RULE7
		bit_cnt_q <= `FRAME_CNT_W'(`FRAME_BITS)) else $error("frame bit counter ran past 32");

	// =================================================================
	// system domain: synchronisers
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic new_frame;
	logic [`PI_W-1:0] pi_s1_q;
	logic [`PI_W-1:0] pi_s2_q;
	logic [`PI_W-1:0] pi_s3_q;
	logic [`GS_W-1:0] gs_s1_q;
	logic [`GS_W-1:0] gs_s2_q;
	logic [`GS_W-1:0] gs_s3_q;
	logic sleep_s1_q;
	logic sleep_s2_q;
	logic fault_s1_q;
	logic fault_s2_q;

	// two flops per crossing; the third stage only keeps history for edges
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			req_s1_q   <= 1'b0;
			req_s2_q   <= 1'b0;
			req_s3_q   <= 1'b0;
			pi_s1_q    <= '0;
			pi_s2_q    <= '0;
			pi_s3_q    <= '0;
			gs_s1_q    <= '0;
			gs_s2_q    <= '0;
			gs_s3_q    <= '0;
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
			fault_s1_q <= 1'b0;
			fault_s2_q <= 1'b0;
		end else begin
			req_s1_q   <= req_tgl_q;
			req_s2_q   <= req_s1_q;
			req_s3_q   <= req_s2_q;
			pi_s1_q    <= programmable_input_in;
			pi_s2_q    <= pi_s1_q;
			pi_s3_q    <= pi_s2_q;
			gs_s1_q    <= ground_switch_input_in;
			gs_s2_q    <= gs_s1_q;
			gs_s3_q    <= gs_s2_q;
			sleep_s1_q <= sleep_state_in;
			sleep_s2_q <= sleep_s1_q;
			fault_s1_q <= fault_summary_in;
			fault_s2_q <= fault_s1_q;
		end
	end

	assign new_frame = req_s2_q ^ req_s3_q;

	// =================================================================
	// register file
	switch_irq_pkg::reg_addr_t frame_addr;
	switch_irq_pkg::access_t   frame_rw;
	logic [`PI_W-1:0]          frame_pi_data;
	logic [`GS_W-1:0]          frame_gs_data;
	logic [`CFG_W-1:0]         frame_cfg_data;
	logic [`PI_W-1:0]          pi_en_q;
	logic [`GS_W-1:0]          gs_en_q;
	logic [`CFG_W-1:0]         sleep_cfg_q;
	logic                      wr_en;
	logic [`RESP_DATA_W-1:0]   rd_data;

	assign frame_addr     = frame_hold_q[`ADDR_MSB:`ADDR_LSB];
	assign frame_rw       = switch_irq_pkg::access_t'(frame_hold_q[`RW_BIT]);
	assign frame_pi_data  = frame_hold_q[`PI_W-1:0];
	assign frame_gs_data  = frame_hold_q[`GS_W-1:0];
	assign frame_cfg_data = frame_hold_q[`CFG_W-1:0];
	assign wr_en          = new_frame && (frame_rw == switch_irq_pkg::ACC_WRITE);

	// writes keep only implemented bits; reads never touch the registers
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pi_en_q     <= `PI_IRQ_EN_RST; // RULE4
			gs_en_q     <= `GS_IRQ_EN_RST; // RULE4
			sleep_cfg_q <= `SLEEP_CFG_RST; // RULE9
		end else if (wr_en) begin
			case (frame_addr)
				`ADDR_PI_IRQ_EN: pi_en_q     <= frame_pi_data; // RULE5 RULE3 RULE16 RULE17
				`ADDR_GS_IRQ_EN: gs_en_q     <= frame_gs_data; // RULE6 RULE3 RULE16 RULE17
				`ADDR_SLEEP_CFG: sleep_cfg_q <= frame_cfg_data; // RULE9 RULE16
				default: begin
				end
			endcase
		end
	end

	// read mux: unused bits and unknown addresses give zero
	always_comb begin
		rd_data = '0;
		case (frame_addr)
			`ADDR_PI_IRQ_EN: rd_data[`PI_W-1:0]  = pi_en_q; // RULE5 RULE16
			`ADDR_GS_IRQ_EN: rd_data[`GS_W-1:0]  = gs_en_q; // RULE6 RULE16
			`ADDR_SLEEP_CFG: rd_data[`CFG_W-1:0] = sleep_cfg_q; // RULE9 RULE16
			default:         rd_data = '0;
		endcase
	end

	// =================================================================
	// interrupt flag; a new frame reports it and clears it, set wins
	logic irq_flag_q;
	logic irq_set;
	logic pi_hit;
	logic gs_hit;
	logic wake_pulse;

	// change of state only interrupts in normal mode and when enabled
	assign pi_hit  = !sleep_s2_q && |((pi_s2_q ^ pi_s3_q) & pi_en_q); // RULE1 RULE2
	assign gs_hit  = !sleep_s2_q && |((gs_s2_q ^ gs_s3_q) & gs_en_q); // RULE1 RULE2
	assign irq_set = pi_hit || gs_hit || wake_pulse; // RULE10

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_flag_q <= 1'b0;
		end else if (irq_set) begin
			irq_flag_q <= 1'b1;
		end else if (new_frame) begin
			irq_flag_q <= 1'b0;
		end
	end

	// return word for the next frame, built from pre-write contents
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			resp_q <= '0;
		end else if (new_frame) begin
			resp_q[`ADDR_MSB:`RW_BIT]           <= frame_hold_q[`ADDR_MSB:`RW_BIT];
			resp_q[`RESP_FAULT_BIT]             <= fault_s2_q; // RULE8
			resp_q[`RESP_IRQ_BIT]               <= irq_flag_q; // RULE8
			resp_q[`RESP_DATA_MSB:0]            <= rd_data;    // RULE8
		end
	end

	assign irq_flag_out = irq_flag_q;

	// =================================================================
	// sleep timers
	switch_irq_pkg::sel_code_t wake_code;
	switch_irq_pkg::sel_code_t poll_code;
	logic                      poll_pulse;

	assign wake_code = sleep_cfg_q[`WAKE_MSB:`WAKE_LSB];
	assign poll_code = sleep_cfg_q[`POLL_MSB:`POLL_LSB];

	// wake timer runs only while asleep; a zero period keeps it silent
	interval_timer #(
		.TICK_CYCLES (MS_TICK_CYCLES)
	) u_wake_timer (
		.sys_clk_in   (sys_clk_in),
		.sys_rst_in   (sys_rst_in),
		.run_in       (sleep_s2_q && (wake_code != `WAKE_OFF)), // RULE10 RULE11
		.period_ms_in (wake_ms(wake_code)),
		.expire_out   (wake_pulse)
	);

	// poll timer sets the spacing of polling events while asleep
	interval_timer #(
		.TICK_CYCLES (MS_TICK_CYCLES)
	) u_poll_timer (
		.sys_clk_in   (sys_clk_in),
		.sys_rst_in   (sys_rst_in),
		.run_in       (sleep_s2_q), // RULE12
		.period_ms_in (poll_ms(poll_code)),
		.expire_out   (poll_pulse)
	);

	assign wake_out = wake_pulse;

	// =================================================================
	// current source windows, each with its own length
	logic [`ON_CNT_W-1:0] ground_cnt_q;
	logic [`ON_CNT_W-1:0] battery_cnt_q;
	logic                 ground_on_q;
	logic                 battery_on_q;

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ground_cnt_q <= '0;
			ground_on_q  <= 1'b0;
		end else begin
			ground_on_q <= poll_pulse || (ground_cnt_q > `ON_CNT_W'(1)); // RULE13
			if (poll_pulse) begin
				ground_cnt_q <= `ON_CNT_W'(GROUND_ON_CYCLES);
			end else if (ground_cnt_q != '0) begin
				ground_cnt_q <= ground_cnt_q - `ON_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			battery_cnt_q <= '0;
			battery_on_q  <= 1'b0;
		end else begin
			battery_on_q <= poll_pulse || (battery_cnt_q > `ON_CNT_W'(1)); // RULE13
			if (poll_pulse) begin
				battery_cnt_q <= `ON_CNT_W'(BATTERY_ON_CYCLES);
			end else if (battery_cnt_q != '0) begin
				battery_cnt_q <= battery_cnt_q - `ON_CNT_W'(1);
			end
		end
	end

	assign ground_poll_on_out  = ground_on_q;
	assign battery_poll_on_out = battery_on_q;

	// =================================================================
	// checks
	chk_mask_blocks_irq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE1
		!irq_flag_q && ((pi_s2_q ^ pi_s3_q) & pi_en_q) == '0 && ((gs_s2_q ^ gs_s3_q) & gs_en_q) == '0
		&& !wake_pulse |=> !irq_flag_q) else $error("flag rose without an enabled cause");
	chk_enabled_change_irq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE2
		!sleep_s2_q && |((pi_s2_q ^ pi_s3_q) & pi_en_q) |=> irq_flag_q)
		else $error("enabled input change did not raise the flag");
	chk_write_pi_en: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE3
		wr_en && frame_addr == `ADDR_PI_IRQ_EN |=> pi_en_q == $past(frame_pi_data))
		else $error("programmable input enable write not taken");
	chk_reset_enables: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE4
		$past(sys_rst_in) |-> pi_en_q == `PI_IRQ_EN_RST && gs_en_q == `GS_IRQ_EN_RST)
		else $error("enables not all ones after reset");
	chk_read_keeps_regs: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE17
		new_frame && frame_rw == switch_irq_pkg::ACC_READ |=> $stable(pi_en_q) && $stable(gs_en_q)
		&& $stable(sleep_cfg_q)) else $error("read access changed a register");
	chk_unused_zero: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE16
		new_frame |=> resp_q[`RESP_DATA_MSB:`GS_W] == '0)
		else $error("unused data bits read non-zero");
	chk_resp_irq_bit: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE8
		new_frame |=> resp_q[`RESP_IRQ_BIT] == $past(irq_flag_q) && resp_q[`RESP_FAULT_BIT] == $past(fault_s2_q))
		else $error("return word flags wrong");
	chk_wake_off: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE11
		wake_code == `WAKE_OFF && $past(wake_code) == `WAKE_OFF |-> !wake_pulse)
		else $error("wake fired while switched off");
	chk_wake_irq: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE10
		wake_pulse |=> irq_flag_q) else $error("wake expiry did not raise the flag");
	chk_poll_windows: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RULE13
		poll_pulse |=> ground_on_q && battery_on_q ##1 ground_on_q && battery_on_q)
		else $error("poll event did not open both windows");

endmodule

// *** design/switch_irq_pkg.sv ***
// types shared by the switch interrupt mask and sleep timer block
package switch_irq_pkg;

	// =================================================================
	// frame pieces
	typedef logic [6:0]  reg_addr_t;
	typedef logic [31:0] frame_word_t;
	typedef logic [3:0]  sel_code_t;
	typedef logic [9:0]  ms_count_t;

	// read/write selector carried in the frame
	typedef enum logic {
		ACC_READ  = 1'b0,
		ACC_WRITE = 1'b1
	} access_t;

endpackage

// *** verif/spi_host_model.sv ***
// host microcontroller model driving the serial register link
`timescale 1ns/1ps

module spi_host_model (
	output logic      spi_sclk_out,
	output logic      spi_cs_n_out,
	output logic      spi_mosi_out,
	input  wire logic spi_miso_in
);
	// ==========================================================
	// idle link: clock parked low, chip select high
	initial begin
		spi_sclk_out = 1'b0;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = 1'b0;
	end

	// one 32-bit frame, msb first; miso read just before each rising edge
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		#13; // offset keeps the link out of phase with the system clock
		spi_cs_n_out = 1'b0;
		for (int k = 31; k >= 0; k--) begin
			spi_mosi_out = tx[k];
			#62.5;
			rx[k] = spi_miso_in;
			spi_sclk_out = 1'b1;
			#62.5;
			spi_sclk_out = 1'b0;
		end
		#62.5;
		spi_cs_n_out = 1'b1;
		spi_mosi_out = ~spi_mosi_out; // released line must not look held
		#400; // gap above the 150 ns the return word needs to settle
	endtask
endmodule

// *** verif/switch_irq_mask_bench.sv ***
// self-checking bench for the switch interrupt mask and sleep timer block
`timescale 1ns/1ps
`define check_eq(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("[FAIL] t=%0t got %0h exp %0h", $time, (got), (exp)); \
	end \
end

module switch_irq_mask_bench;
	logic        sys_clk_in;
	logic        sys_rst_in;
	logic        spi_sclk;
	logic        spi_cs_n;
	logic        spi_mosi;
	logic        spi_miso;
	logic        spi_miso_oe_n;
	logic [7:0]  programmable_input_in;
	logic [13:0] ground_switch_input_in;
	logic        sleep_state_in;
	logic        fault_summary_in;
	logic        irq_flag_out;
	logic        wake_out;
	logic        ground_poll_on_out;
	logic        battery_poll_on_out;
	int          n_errors = 0;
	int          checks = 0;
	int          cycles = 0;

	// ==========================================================
	// short ms tick so sleep timers fit the run: 1 ms = 20 cycles
	switch_irq_mask #(.MS_TICK_CYCLES(20), .GROUND_POLL_ON_US(1), .BATTERY_POLL_ON_US(2)) switch_irq_mask_i (
		.sys_clk_in             (sys_clk_in),
		.sys_rst_in             (sys_rst_in),
		.spi_sclk_in            (spi_sclk),
		.spi_cs_n_in            (spi_cs_n),
		.spi_mosi_in            (spi_mosi),
		.spi_miso_out           (spi_miso),
		.spi_miso_oe_n_out      (spi_miso_oe_n),
		.programmable_input_in  (programmable_input_in),
		.ground_switch_input_in (ground_switch_input_in),
		.sleep_state_in         (sleep_state_in),
		.fault_summary_in       (fault_summary_in),
		.irq_flag_out           (irq_flag_out),
		.wake_out               (wake_out),
		.ground_poll_on_out     (ground_poll_on_out),
		.battery_poll_on_out    (battery_poll_on_out)
	);

	spi_host_model spi_host_model_i (
		.spi_sclk_out (spi_sclk),
		.spi_cs_n_out (spi_cs_n),
		.spi_mosi_out (spi_mosi),
		.spi_miso_in  (spi_miso)
	);

	// ==========================================================
	// 20 MHz system clock and hang guard
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one frame; rx is the return word of the frame before
	task automatic acc(input logic [6:0] a, input logic w, input logic [23:0] d, output logic [31:0] rx);
		spi_host_model_i.xfer({a, w, d}, rx);
	endtask

	// ==========================================================
	// scenarios
	task automatic test_reset_values();
		logic [31:0] rx;
		logic [6:0]  adr [4] = '{7'h0d, 7'h0e, 7'h0f, 7'h10};
		logic [21:0] val [4] = '{22'hff, 22'h3fff, 22'h0f, 22'h0};
		`check_eq(spi_miso_oe_n, 1'b1)
		acc(adr[0], 1'b0, 24'h0, rx);
		for (int k = 1; k <= 4; k++) begin
			acc(adr[k % 4], 1'b0, 24'h0, rx);
			`check_eq(rx, {adr[k - 1], 1'b0, 2'b00, val[k - 1]})
		end
		$display("test reset values done");
	endtask

	task automatic test_write_fields();
		logic [31:0] rx;
		@(negedge sys_clk_in);
		fault_summary_in = 1'b1;
		acc(7'h0d, 1'b1, 24'hffff5a, rx);
		acc(7'h0e, 1'b1, 24'hffc000, rx);
		`check_eq(rx, {7'h0d, 1'b1, 2'b10, 22'hff})
		acc(7'h0d, 1'b0, 24'h0, rx);
		`check_eq(rx, {7'h0e, 1'b1, 2'b10, 22'h3fff})
		acc(7'h0e, 1'b0, 24'h0, rx);
		`check_eq(rx, {7'h0d, 1'b0, 2'b10, 22'h5a})
		acc(7'h0d, 1'b0, 24'h0, rx);
		`check_eq(rx, {7'h0e, 1'b0, 2'b10, 22'h0})
		@(negedge sys_clk_in);
		fault_summary_in = 1'b0;
		acc(7'h0f, 1'b0, 24'h0, rx);
		`check_eq(rx, {7'h0d, 1'b0, 2'b10, 22'h5a})
		$display("test write fields done");
	endtask

	// flip one input (0..7 programmable, 8..21 ground) and judge the flag
	task automatic flip(input int idx, input logic exp);
		@(negedge sys_clk_in);
		if (idx < 8) programmable_input_in[idx] = ~programmable_input_in[idx];
		else ground_switch_input_in[idx - 8] = ~ground_switch_input_in[idx - 8];
		repeat (8) @(negedge sys_clk_in);
		`check_eq(irq_flag_out, exp)
	endtask

	task automatic test_irq_mask();
		logic [31:0] rx;
		flip(0, 1'b0);
		flip(13, 1'b0);
		flip(1, 1'b1);
		acc(7'h0d, 1'b1, 24'h000001, rx);
		`check_eq(irq_flag_out, 1'b0)
		acc(7'h0d, 1'b0, 24'h0, rx);
		`check_eq(rx, {7'h0d, 1'b1, 2'b01, 22'h5a})
		flip(1, 1'b0);
		flip(0, 1'b1);
		acc(7'h0e, 1'b1, 24'h000020, rx);
		flip(13, 1'b1);
		$display("test irq mask done");
	endtask

	// sleep with the given codes; wcyc and pcyc are the wake and poll periods in cycles (1 ms = 20)
	task automatic test_sleep(input logic [3:0] wcode, input logic [3:0] pcode, input int wcyc, input int pcyc,
		input int n);
		logic [31:0] rx;
		int          wk = -1;
		int          lr = -1;
		int          gl = 0;
		int          bl = 0;
		logic        gp = 1'b0;
		acc(7'h0f, 1'b1, {16'h0, wcode, pcode}, rx);
		@(negedge sys_clk_in);
		sleep_state_in = 1'b1;
		for (int c = 0; c < n; c++) begin
			@(negedge sys_clk_in);
			if (wk < 0) `check_eq(irq_flag_out, 1'b0)
			if (wk >= 0 && wk == c - 1) `check_eq(irq_flag_out, 1'b1)
			if (wake_out === 1'b1 && wk < 0) wk = c;
			if (ground_poll_on_out === 1'b1 && !gp && lr >= 0) `check_eq(c - lr, pcyc)
			if (ground_poll_on_out === 1'b1 && !gp) lr = c;
			gp = ground_poll_on_out;
			if (ground_poll_on_out === 1'b1) gl++;
			else if (gl != 0) begin
				`check_eq(gl, 20)
				gl = 0;
			end
			if (battery_poll_on_out === 1'b1) bl++;
			else if (bl != 0) begin
				`check_eq(bl, 40)
				bl = 0;
			end
		end
		`check_eq(lr >= 0, 1'b1)
		`check_eq(wcode == 4'h0 ? wk < 0 : (wk >= wcyc && wk <= wcyc + 8), 1'b1)
		@(negedge sys_clk_in);
		sleep_state_in = 1'b0;
		repeat (60) @(negedge sys_clk_in);
		$display("test sleep code %0h done", wcode);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		sys_rst_in = 1'b1;
		programmable_input_in = 8'h00;
		ground_switch_input_in = 14'h0000;
		sleep_state_in = 1'b0;
		fault_summary_in = 1'b0;
		repeat (20) @(negedge sys_clk_in);
		sys_rst_in = 1'b0;
		repeat (5) @(negedge sys_clk_in);
		test_reset_values();
		test_write_fields();
		test_irq_mask();
		test_sleep(4'h8, 4'h0, 80, 60, 200);
		test_sleep(4'h0, 4'h0, 0, 60, 400);
		test_sleep(4'h1, 4'h1, 120, 120, 300);
		print_verdict();
	end
endmodule
